// [thermal_host_model.sv]
// host-side model that issues register reads and writes
`timescale 1ns/100ps
`default_nettype none
module thermal_host_model (
   input wire logic clk_sys_in,
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_rd_out
);
   // idle bus at time zero
   initial begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_rd_out = 1'b0;
   end
   // one-cycle write strobe; pointer and data stop holding afterwards
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask
   // write then read back to back, with no idle cycle between them
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] ra);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ra;
      reg_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~ra;
      reg_wdata_out <= ~d;
   endtask
   // one-cycle read strobe, answer comes from the block a cycle later
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
   endtask
endmodule // thermal_host_model
`default_nettype wire

// [thermal_monitor_map.svh]
// register pointers, reset values and field positions of the monitor
`ifndef THERMAL_MONITOR_MAP_SVH
`define THERMAL_MONITOR_MAP_SVH
`define PTR_ITEMP 8'h00
`define PTR_RTEMP 8'h01
`define PTR_STATUS 8'h02
`define PTR_CFG 8'h03
`define PTR_RATE 8'h04
`define PTR_IHI 8'h05
`define PTR_ILO 8'h06
`define PTR_RHI 8'h07
`define PTR_RLO 8'h08
`define PTR_CFG_M 8'h09
`define PTR_RATE_M 8'h0a
`define PTR_IHI_M 8'h0b
`define PTR_ILO_M 8'h0c
`define PTR_RHI_M 8'h0d
`define PTR_RLO_M 8'h0e
`define PTR_RFRAC 8'h10
`define PTR_SCR_A 8'h11
`define PTR_SCR_B 8'h12
`define PTR_RHIF 8'h13
`define PTR_RLOF 8'h14
`define PTR_RCRIT 8'h19
`define PTR_LINK 8'h1d
`define PTR_HWLIM 8'h1e
`define PTR_MASK 8'h1f
`define PTR_ICRIT 8'h20
`define PTR_HYST 8'h21
`define PTR_CONSEC 8'h22
`define PTR_IFRAC 8'h29
`define PTR_HIFLG 8'h35
`define PTR_LOFLG 8'h36
`define PTR_CRFLG 8'h37
`define PTR_FILT 8'h40
`define PTR_PROD 8'hfd
`define PTR_MAKER 8'hfe
`define PTR_REV 8'hff
`define RST_ZERO 8'h00
`define RST_RATE 8'h06
`define RST_LIMIT 8'h55
`define RST_HYST 8'h0a
`define RST_CONSEC 8'h70
`define CH_INT 0
`define CH_REM 1
`define ST_BUSY 7
`define ST_HIGH 4
`define ST_LOW 3
`define ST_FAULT 2
`define ST_CRIT 1
`define ST_HWSD 0
`define FRAC_MSB 7
`define FRAC_LSB 5
`endif

// [thermal_monitor_pkg.sv]
// types shared by the thermal monitor register bank
package thermal_monitor_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] frac_t;
   typedef struct packed {
      byte_t cfg;
      byte_t rate;
      byte_t ihi;
      byte_t ilo;
      byte_t rhi;
      byte_t rlo;
      byte_t rhif;
      byte_t rlof;
      byte_t scr_a;
      byte_t scr_b;
      byte_t rcrit;
      byte_t icrit;
      byte_t hyst;
      byte_t link;
      byte_t mask;
      byte_t consec;
      byte_t filt;
      byte_t hwlim;
      logic strap_done;
      byte_t itemp;
      frac_t ifrac;
      byte_t rtemp;
      frac_t rfrac;
      frac_t ishadow;
      frac_t rshadow;
      logic [1:0] hiflg;
      logic [1:0] loflg;
      logic [1:0] crflg;
      logic fault;
      logic busy;
      logic hwsd;
      logic shdn;
      byte_t rdata;
   } state_s;
endpackage

// [thermal_monitor_register_map_tb.sv]
// self-checking testbench of the thermal monitor register bank
`timescale 1ns/100ps
`default_nettype none
module thermal_monitor_register_map_tb;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic meas_valid_in = 1'b0;
   logic [7:0] int_temp_in = 8'h00;
   logic [2:0] int_frac_in = 3'h0;
   logic [7:0] rem_temp_in = 8'h00;
   logic [2:0] rem_frac_in = 3'h0;
   logic diode_fault_in = 1'b0;
   logic busy_in = 1'b0;
   logic [7:0] hw_limit_in = 8'h70;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_out, config_out, conv_rate_out;
   logic [7:0] filter_out, channel_mask_out, consec_alert_out, d;
   logic reg_wr, reg_rd, system_shutdown_output_out;
   logic rd_pend = 1'b0;
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 50;
   logic [7:0] exp_q [$];
   logic [7:0] m [256];
   // {read-only, pointer, reset value}
   logic [16:0] tbl [36] = '{17'h10000, 17'h10100, 17'h10200, 17'h00300,
      17'h00406, 17'h00555, 17'h00600, 17'h00755, 17'h00800, 17'h00900,
      17'h00a06, 17'h00b55, 17'h00c00, 17'h00d55, 17'h00e00, 17'h11000,
      17'h01100, 17'h01200, 17'h01300, 17'h01400, 17'h01955, 17'h01d00,
      17'h11e70, 17'h01f00, 17'h02055, 17'h0210a, 17'h02270, 17'h12900,
      17'h13500, 17'h13600, 17'h13700, 17'h04000, 17'h1fda5, 17'h1fe3c,
      17'h1ff07, 17'h10f00};
   // {written pointer, read-back pointer}
   logic [15:0] rw [17] = '{16'h0903, 16'h0a04, 16'h050b, 16'h0c06,
      16'h070d, 16'h0e08, 16'h1111, 16'h1212, 16'h1313, 16'h1414,
      16'h1919, 16'h1d1d, 16'h1f1f, 16'h2020, 16'h2121, 16'h2222,
      16'h4040};

   // 100 MHz system clock
   always #5 clk_sys_in = ~clk_sys_in;

   thermal_monitor_regs dut (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in),
      .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
      .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
      .meas_valid_in(meas_valid_in), .int_temp_in(int_temp_in),
      .int_frac_in(int_frac_in), .rem_temp_in(rem_temp_in),
      .rem_frac_in(rem_frac_in), .diode_fault_in(diode_fault_in),
      .busy_in(busy_in), .hw_limit_in(hw_limit_in),
      .reg_rdata_out(reg_rdata_out), .config_out(config_out),
      .conv_rate_out(conv_rate_out), .filter_out(filter_out),
      .channel_mask_out(channel_mask_out),
      .consec_alert_out(consec_alert_out),
      .system_shutdown_output_out(system_shutdown_output_out));

   thermal_host_model host (
      .clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr),
      .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata),
      .reg_rd_out(reg_rd));

   // compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // note the expected answer, then issue the read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask

   // one conversion-done pulse with its results
   task automatic meas(input logic [7:0] ti, input logic [2:0] fi,
      input logic [7:0] tr, input logic [2:0] fr, input logic flt);
      @(posedge clk_sys_in);
      int_temp_in <= ti;
      int_frac_in <= fi;
      rem_temp_in <= tr;
      rem_frac_in <= fr;
      diode_fault_in <= flt;
      meas_valid_in <= 1'b1;
      @(posedge clk_sys_in);
      meas_valid_in <= 1'b0;
      int_temp_in <= ~ti;
      rem_temp_in <= ~tr;
   endtask

   // verdict and end of run
   task automatic close_out;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // track accepted reads
   always @(posedge clk_sys_in) begin
      rd_pend <= reg_rd & ce_in;
   end

   // compare each read answer with the oldest note once settled
   always @(negedge clk_sys_in) begin
      if (rd_pend) begin
         if (exp_q.size() > 0)
            check(reg_rdata_out, exp_q.pop_front());
         else
            error_cnt++;
      end
   end

   // cut a hang short
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      error_cnt++;
      close_out();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      // reset values, identity bytes and unmapped reads
      foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][7:0]);
      // writes to read-only and unmapped places change nothing
      foreach (tbl[i]) begin
         if (tbl[i][16]) begin
            host.wr(tbl[i][15:8], ~tbl[i][7:0]);
            rd(tbl[i][15:8], tbl[i][7:0]);
         end
      end
      // conversion results, flags and status
      busy_in <= 1'b1;
      meas(8'h60, 3'h5, 8'h40, 3'h3, 1'b0);
      rd(8'h00, 8'h60);
      rd(8'h01, 8'h40);
      rd(8'h02, 8'h92);
      rd(8'h35, 8'h01);
      rd(8'h35, 8'h00);
      rd(8'h36, 8'h00);
      rd(8'h37, 8'h01);
      @(negedge clk_sys_in);
      check({7'h00, system_shutdown_output_out}, 8'h00);
      // fractions come from the copy taken at the integer read
      meas(8'h60, 3'h2, 8'h40, 3'h6, 1'b0);
      rd(8'h29, 8'ha0);
      rd(8'h10, 8'h60);
      rd(8'h00, 8'h60);
      rd(8'h29, 8'h40);
      // link the internal critical flag to the shutdown pin
      host.wr(8'h1d, 8'h01);
      meas(8'h60, 3'h0, 8'h40, 3'h0, 1'b0);
      @(negedge clk_sys_in);
      check({7'h00, system_shutdown_output_out}, 8'h01);
      // cooling below limit minus hysteresis, remote diode faulty
      meas(8'h20, 3'h0, 8'h50, 3'h7, 1'b1);
      @(negedge clk_sys_in);
      check({7'h00, system_shutdown_output_out}, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h10, 8'h00);
      // read-write places hold what was written; mirrors share storage
      foreach (rw[i]) begin
         d = 8'($random(seed));
         m[rw[i][15:8]] = d;
         host.wr(rw[i][15:8], d);
         rd(rw[i][7:0], d);
      end
      @(negedge clk_sys_in);
      check(config_out, m[8'h09]);
      check(conv_rate_out, m[8'h0a]);
      check(filter_out, m[8'h40]);
      check(channel_mask_out, m[8'h1f]);
      check(consec_alert_out, m[8'h22]);
      // a write while the clock enable is low is lost
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      host.wr(8'h11, ~m[8'h11]);
      ce_in <= 1'b1;
      rd(8'h11, m[8'h11]);
      // rate written at its mirror and read at once at the main pointer
      d = 8'($random(seed));
      exp_q.push_back(d);
      host.wr_rd(8'h0a, d, 8'h04);
      // clear the internal high flag left by the earlier conversions
      rd(8'h35, 8'h01);
      // masked internal channel stays quiet; remote trips on fraction
      host.wr(8'h1f, 8'h01);
      host.wr(8'h05, 8'h10);
      host.wr(8'h07, 8'h40);
      host.wr(8'h13, 8'h80);
      meas(8'h30, 3'h0, 8'h40, 3'h5, 1'b0);
      rd(8'h35, 8'h02);
      repeat (3) @(posedge clk_sys_in);
      close_out();
   end
endmodule // thermal_monitor_register_map_tb
`default_nettype wire

// [thermal_monitor_regs.sv]
// register bank of the two-channel thermal monitor
`timescale 1ns/100ps
`default_nettype none
`include "thermal_monitor_map.svh"
module thermal_monitor_regs #(
   parameter logic [7:0] PRODUCT_IDENTIFIER = 8'ha5, // arbitrary value
   parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h07, // arbitrary value
   parameter int TEMP_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic meas_valid_in,
   input wire logic [7:0] int_temp_in,
   input wire logic [2:0] int_frac_in,
   input wire logic [7:0] rem_temp_in,
   input wire logic [2:0] rem_frac_in,
   input wire logic diode_fault_in,
   input wire logic busy_in,
   input wire logic [7:0] hw_limit_in,
   output logic [7:0] reg_rdata_out,
   output logic [7:0] config_out,
   output logic [7:0] conv_rate_out,
   output logic [7:0] filter_out,
   output logic [7:0] channel_mask_out,
   output logic [7:0] consec_alert_out,
   output logic system_shutdown_output_out
);

   // elaboration check: the map is built for byte-wide temperatures
   if (TEMP_W != 8) begin : g_bad_width
      $error("TEMP_W must be 8");
   end

   thermal_monitor_pkg::state_s s_q;
   thermal_monitor_pkg::state_s s_d;

   // 11-bit value built from integer byte and 3 fraction bits
   function automatic logic [10:0] full_val(input logic [7:0] i,
                                            input logic [2:0] f);
      full_val = {i, f};
   endfunction

   // critical flag with hysteresis: set above limit, clear at limit-hyst
   function automatic logic crit_next(input logic flag,
                                      input logic [7:0] t,
                                      input logic [7:0] lim,
                                      input logic [7:0] hy);
      logic [8:0] rel;
      rel = {1'b0, lim} - {1'b0, hy};
      if (t > lim) begin
         crit_next = 1'b1;
      end else if (rel[8] || ({1'b0, t} <= rel)) begin
         crit_next = 1'b0;
      end else begin
         crit_next = flag;
      end
   endfunction

   // read mux; temperature fraction registers (10h, 29h) keep unused low bits at zero
   function automatic logic [7:0] read_mux(
      input thermal_monitor_pkg::state_s s, input logic [7:0] a);
      logic [7:0] st;
      st = '0;
      st[`ST_BUSY] = s.busy;
      st[`ST_HIGH] = |s.hiflg;
      st[`ST_LOW] = |s.loflg;
      st[`ST_FAULT] = s.fault;
      st[`ST_CRIT] = |s.crflg;
      st[`ST_HWSD] = s.hwsd;
      unique case (a)
         `PTR_ITEMP: read_mux = s.itemp;
         `PTR_RTEMP: read_mux = s.rtemp;
         `PTR_STATUS: read_mux = st;
         `PTR_CFG, `PTR_CFG_M: read_mux = s.cfg;
         `PTR_RATE, `PTR_RATE_M: read_mux = s.rate;
         `PTR_IHI, `PTR_IHI_M: read_mux = s.ihi;
         `PTR_ILO, `PTR_ILO_M: read_mux = s.ilo;
         `PTR_RHI, `PTR_RHI_M: read_mux = s.rhi;
         `PTR_RLO, `PTR_RLO_M: read_mux = s.rlo;
         `PTR_RFRAC: read_mux = {s.rshadow, 5'h00};
         `PTR_IFRAC: read_mux = {s.ishadow, 5'h00};
         `PTR_SCR_A: read_mux = s.scr_a;
         `PTR_SCR_B: read_mux = s.scr_b;
         `PTR_RHIF: read_mux = s.rhif;
         `PTR_RLOF: read_mux = s.rlof;
         `PTR_RCRIT: read_mux = s.rcrit;
         `PTR_ICRIT: read_mux = s.icrit;
         `PTR_HYST: read_mux = s.hyst;
         `PTR_LINK: read_mux = s.link;
         `PTR_HWLIM: read_mux = s.hwlim;
         `PTR_MASK: read_mux = s.mask;
         `PTR_CONSEC: read_mux = s.consec;
         `PTR_HIFLG: read_mux = {6'h00, s.hiflg};
         `PTR_LOFLG: read_mux = {6'h00, s.loflg};
         `PTR_CRFLG: read_mux = {6'h00, s.crflg};
         `PTR_FILT: read_mux = s.filt;
         `PTR_PROD: read_mux = PRODUCT_IDENTIFIER;
         `PTR_MAKER: read_mux = MAKER_ID;
         `PTR_REV: read_mux = REVISION_ID;
         default: read_mux = 8'h00;
      endcase
   endfunction

   // next-state logic: register writes, reads, measurement updates
   always_comb begin
      logic rd;
      logic wr;
      logic [1:0] hi_set;
      logic [1:0] lo_set;
      rd = ce_in && reg_rd_in;
      wr = ce_in && reg_wr_in;
      hi_set = 2'b00;
      lo_set = 2'b00;
      s_d = s_q;
      // the strap is sampled once, in the first enabled cycle
      if (ce_in && !s_q.strap_done) begin
         s_d.hwlim = hw_limit_in;
         s_d.strap_done = 1'b1;
      end
      // writes land only on read-write pointers; others drop
      if (wr) begin
         unique case (reg_addr_in)
            `PTR_CFG, `PTR_CFG_M: s_d.cfg = reg_wdata_in;
            `PTR_RATE, `PTR_RATE_M: s_d.rate = reg_wdata_in;
            `PTR_IHI, `PTR_IHI_M: s_d.ihi = reg_wdata_in;
            `PTR_ILO, `PTR_ILO_M: s_d.ilo = reg_wdata_in;
            `PTR_RHI, `PTR_RHI_M: s_d.rhi = reg_wdata_in;
            `PTR_RLO, `PTR_RLO_M: s_d.rlo = reg_wdata_in;
            `PTR_SCR_A: s_d.scr_a = reg_wdata_in;
            `PTR_SCR_B: s_d.scr_b = reg_wdata_in;
            `PTR_RHIF: s_d.rhif = reg_wdata_in;
            `PTR_RLOF: s_d.rlof = reg_wdata_in;
            `PTR_RCRIT: s_d.rcrit = reg_wdata_in;
            `PTR_ICRIT: s_d.icrit = reg_wdata_in;
            `PTR_HYST: s_d.hyst = reg_wdata_in;
            `PTR_LINK: s_d.link = reg_wdata_in;
            `PTR_MASK: s_d.mask = reg_wdata_in;
            `PTR_CONSEC: s_d.consec = reg_wdata_in;
            `PTR_FILT: s_d.filt = reg_wdata_in;
            default: ;
         endcase
      end
      // reads: data out, shadow capture, clear-on-read
      if (rd) begin
         s_d.rdata = read_mux(s_q, reg_addr_in);
         if (reg_addr_in == `PTR_ITEMP) begin
            s_d.ishadow = s_q.ifrac;
         end
         if (reg_addr_in == `PTR_RTEMP) begin
            s_d.rshadow = s_q.rfrac;
         end
         if (reg_addr_in == `PTR_HIFLG) begin
            s_d.hiflg = 2'b00;
         end
         if (reg_addr_in == `PTR_LOFLG) begin
            s_d.loflg = 2'b00;
         end
      end
      // a finished conversion updates data and limit flags
      if (ce_in && meas_valid_in) begin
         s_d.itemp = int_temp_in;
         s_d.ifrac = int_frac_in;
         s_d.fault = diode_fault_in;
         s_d.rtemp = diode_fault_in ? 8'h00 : rem_temp_in;
         s_d.rfrac = diode_fault_in ? 3'h0 : rem_frac_in;
         hi_set[`CH_INT] = int_temp_in > s_q.ihi;
         lo_set[`CH_INT] = int_temp_in < s_q.ilo;
         hi_set[`CH_REM] = !diode_fault_in &&
            (full_val(rem_temp_in, rem_frac_in) >
             full_val(s_q.rhi, s_q.rhif[`FRAC_MSB:`FRAC_LSB]));
         // a faulted diode skips the low-limit check
         lo_set[`CH_REM] = !diode_fault_in &&
            (full_val(rem_temp_in, rem_frac_in) <
             full_val(s_q.rlo, s_q.rlof[`FRAC_MSB:`FRAC_LSB]));
         s_d.crflg[`CH_INT] = crit_next(s_q.crflg[`CH_INT],
            int_temp_in, s_q.icrit, s_q.hyst);
         s_d.crflg[`CH_REM] = crit_next(s_q.crflg[`CH_REM],
            s_d.rtemp, s_q.rcrit, s_q.hyst);
         s_d.hwsd = s_q.strap_done && (s_d.rtemp > s_q.hwlim);
      end
      // masked channels raise no high or low flags; set beats clear
      s_d.hiflg = s_d.hiflg | (hi_set & ~s_q.mask[1:0]);
      s_d.loflg = s_d.loflg | (lo_set & ~s_q.mask[1:0]);
      if (ce_in) begin
         s_d.busy = busy_in;
         s_d.shdn = s_d.hwsd |
            (|(s_d.crflg & s_q.link[1:0]));
      end
      if (rst_in) begin
         s_d = '0;
         s_d.rate = `RST_RATE;
         s_d.ihi = `RST_LIMIT;
         s_d.rhi = `RST_LIMIT;
         s_d.rcrit = `RST_LIMIT;
         s_d.icrit = `RST_LIMIT;
         s_d.hyst = `RST_HYST;
         s_d.consec = `RST_CONSEC;
      end
   end

   // the whole state is one register
   always_ff @(posedge clk_sys_in) begin
      s_q <= s_d;
   end

   // outputs straight from the state register
   assign reg_rdata_out = s_q.rdata;
   assign config_out = s_q.cfg;
   assign conv_rate_out = s_q.rate;
   assign filter_out = s_q.filt;
   assign channel_mask_out = s_q.mask;
   assign consec_alert_out = s_q.consec;
   assign system_shutdown_output_out = s_q.shdn;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   // mirrored write at 09h is seen as configuration
   a_cfg_mirror: assert property (
      ce_in && reg_wr_in && reg_addr_in == `PTR_CFG_M |=>
      config_out == $past(reg_wdata_in))
      else $error("config mirror write lost");

   a_rate_mirror: assert property (
      ce_in && reg_wr_in && reg_addr_in == `PTR_RATE_M &&
      !reg_rd_in ##1 ce_in && reg_rd_in && reg_addr_in == `PTR_RATE
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("rate mirror mismatch");

   a_unused_zero: assert property (
      ce_in && reg_rd_in && reg_addr_in == `PTR_IFRAC |=>
      reg_rdata_out[4:0] == 5'h00)
      else $error("unused fraction bits not zero");

   a_unmapped_zero: assert property (
      ce_in && reg_rd_in && reg_addr_in == 8'h0f |=>
      reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");

   a_ro_stable: assert property (
      ce_in && reg_wr_in && reg_addr_in == `PTR_ITEMP &&
      !meas_valid_in |=> $stable(s_q.itemp))
      else $error("read-only temperature written");

   a_flag_clear: assert property (
      ce_in && reg_rd_in && reg_addr_in == `PTR_HIFLG &&
      !meas_valid_in |=> s_q.hiflg == 2'b00)
      else $error("high flags not cleared by read");

   a_shadow_latch: assert property (
      ce_in && reg_rd_in && reg_addr_in == `PTR_RTEMP |=>
      s_q.rshadow == $past(s_q.rfrac))
      else $error("remote fraction not latched");

   a_maker_id: assert property (
      ce_in && reg_rd_in && reg_addr_in == `PTR_MAKER |=>
      reg_rdata_out == MAKER_ID)
      else $error("identity byte wrong");

   a_hwlim_fixed: assert property (
      s_q.strap_done |=> $stable(s_q.hwlim) [*3])
      else $error("shutdown threshold changed");

   c_shutdown: cover property (system_shutdown_output_out);
   c_high_flag: cover property (s_q.hiflg != 2'b00);
   c_crit_clear: cover property ($fell(s_q.crflg[`CH_REM]));

endmodule // thermal_monitor_regs
`default_nettype wire
